// ===== inc/stpoc_regs.vh
// Purpose: register indices, field positions and reset values of the
//          sensor timing output polarity control block
// Assumes: byte address on the bus is four times the register index
// Notes:   definitions only, no logic
`ifndef STPOC_REGS_VH
`define STPOC_REGS_VH

// page numbers reached through the bank select register
`define STPOC_PAGE_GATES 4'h7
`define STPOC_PAGE_PHASE 4'h8

// register indices inside a page
`define STPOC_IDX_GATE1 5'h19
`define STPOC_IDX_GATE2 5'h1a
`define STPOC_IDX_GATE3 5'h1b
`define STPOC_IDX_GATE4 5'h1c
`define STPOC_IDX_GATE5 5'h1d
`define STPOC_IDX_RSVD 5'h1e
`define STPOC_IDX_PAGE 5'h1f
`define STPOC_IDX_PHA 5'h00
`define STPOC_IDX_PHB 5'h01
`define STPOC_IDX_PHC 5'h02
`define STPOC_IDX_LINE 5'h1e

// phase pair control field positions
`define STPOC_EN_HI 6
`define STPOC_SRC_HI 5
`define STPOC_POL_HI 4
`define STPOC_EN_LO 2
`define STPOC_SRC_LO 1
`define STPOC_POL_LO 0
`define STPOC_PHASE_MASK 8'h77

// reset values
`define STPOC_RST_INV 4'h0
`define STPOC_RST_PHASE 8'h44
`define STPOC_RST_PAGE 4'h0
`define STPOC_RST_LINE 2'h0

`endif

// ===== design/stpoc_top.v
// Purpose: conditions transfer gate and phase clock waveforms from the
//          timing generator before they leave for the image sensor
// Assumes: classic wishbone slave, 32-bit data, register data in bits 7:0
// Notes:   all outputs registered; waveforms arrive from same-clock logic
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "stpoc_regs.vh"

module stpoc_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [6:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [4:0] gate_wave_i,
  input wire [5:0] phase_wave_i,
  input wire line_start_i,
  output wire [4:0] gate_o,
  output wire [5:0] phase_o,
  output wire [5:0] phase_oe_o,
  output wire [1:0] line_index_o
);

  // bus state
  reg ack_r;
  reg [31:0] rdat_r;
  reg [31:0] rdat_nxt;

  // configuration state
  reg [3:0] page_r;
  reg [19:0] gate_inv_r;
  reg [7:0] pha_r;
  reg [7:0] phb_r;
  reg [7:0] phc_r;

  // line sequencing
  reg [1:0] line_idx_r;

  // conditioned outputs
  reg [4:0] gate_r;
  reg [5:0] phase_r;
  reg [5:0] phase_oe_r;

  // decode helpers
  wire [4:0] idx;
  wire req;
  wire wr;
  wire lane0;
  wire on_page_reg;
  wire on_gates;
  wire on_phase;
  wire [7:0] wbyte;
  wire [4:0] gate_nxt;
  wire [5:0] phase_nxt;
  wire [5:0] phase_oe_nxt;

  // one request per ack; the ack cycle itself never starts a new one
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  // all register data lives in byte lane 0
  assign lane0 = wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign idx = wb_adr_i[6:2];

  // page register is visible on every page
  assign on_page_reg = (idx == `STPOC_IDX_PAGE);
  assign on_gates = ~on_page_reg & (page_r == `STPOC_PAGE_GATES);
  assign on_phase = ~on_page_reg & (page_r == `STPOC_PAGE_PHASE);

  // bus ack: one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // bank select write; upper nibble not stored
  always @(posedge clk_i) begin
    if (rst_i) begin
      page_r <= `STPOC_RST_PAGE;
    end else if (wr && lane0 && on_page_reg) begin
      page_r <= wbyte[3:0];
    end
  end

  // gate override writes; bits 7:4 are not used and are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_inv_r <= {5{`STPOC_RST_INV}};
    end else if (wr && lane0 && on_gates) begin
      case (idx)
        `STPOC_IDX_GATE1: begin
          gate_inv_r[3:0] <= wbyte[3:0];
        end
        `STPOC_IDX_GATE2: begin
          gate_inv_r[7:4] <= wbyte[3:0];
        end
        `STPOC_IDX_GATE3: begin
          gate_inv_r[11:8] <= wbyte[3:0];
        end
        `STPOC_IDX_GATE4: begin
          gate_inv_r[15:12] <= wbyte[3:0];
        end
        `STPOC_IDX_GATE5: begin
          gate_inv_r[19:16] <= wbyte[3:0];
        end
        default: begin
          gate_inv_r <= gate_inv_r;
        end
      endcase
    end
  end

  // phase pair writes; bits 7 and 3 are not used and read as zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      pha_r <= `STPOC_RST_PHASE;
      phb_r <= `STPOC_RST_PHASE;
      phc_r <= `STPOC_RST_PHASE;
    end else if (wr && lane0 && on_phase) begin
      case (idx)
        `STPOC_IDX_PHA: begin
          pha_r <= wbyte & `STPOC_PHASE_MASK;
        end
        `STPOC_IDX_PHB: begin
          phb_r <= wbyte & `STPOC_PHASE_MASK;
        end
        `STPOC_IDX_PHC: begin
          phc_r <= wbyte & `STPOC_PHASE_MASK;
        end
        default: begin
          phc_r <= phc_r;
        end
      endcase
    end
  end

  // read mux; unmapped indices and unknown pages read zero but still ack
  always @* begin
    rdat_nxt = 32'h0000_0000;
    if (on_page_reg) begin
      rdat_nxt[3:0] = page_r;
    end else if (on_gates) begin
      case (idx)
        `STPOC_IDX_GATE1: begin
          rdat_nxt[3:0] = gate_inv_r[3:0];
        end
        `STPOC_IDX_GATE2: begin
          rdat_nxt[3:0] = gate_inv_r[7:4];
        end
        `STPOC_IDX_GATE3: begin
          rdat_nxt[3:0] = gate_inv_r[11:8];
        end
        `STPOC_IDX_GATE4: begin
          rdat_nxt[3:0] = gate_inv_r[15:12];
        end
        `STPOC_IDX_GATE5: begin
          rdat_nxt[3:0] = gate_inv_r[19:16];
        end
        default: begin
          rdat_nxt = 32'h0000_0000;
        end
      endcase
    end else if (on_phase) begin
      case (idx)
        `STPOC_IDX_PHA: begin
          rdat_nxt[7:0] = pha_r;
        end
        `STPOC_IDX_PHB: begin
          rdat_nxt[7:0] = phb_r;
        end
        `STPOC_IDX_PHC: begin
          rdat_nxt[7:0] = phc_r;
        end
        `STPOC_IDX_LINE: begin
          rdat_nxt[1:0] = line_idx_r;
        end
        default: begin
          rdat_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data captured with the request, held through the ack cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (req) begin
      rdat_r <= rdat_nxt;
    end
  end

  // line counter wraps after line 3, matching the four override bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_idx_r <= `STPOC_RST_LINE;
    end else if (line_start_i) begin
      line_idx_r <= line_idx_r + 2'h1;
    end
  end

  // per-gate line inversion; each lane sees only its own four bits
  stpoc_gate_lane u_lane_gate1 (
    .wave_i(gate_wave_i[0]),
    .row_i(gate_inv_r[3:0]),
    .line_i(line_idx_r),
    .lane_o(gate_nxt[0])
  );
  stpoc_gate_lane u_lane_gate2 (
    .wave_i(gate_wave_i[1]),
    .row_i(gate_inv_r[7:4]),
    .line_i(line_idx_r),
    .lane_o(gate_nxt[1])
  );
  stpoc_gate_lane u_lane_gate3 (
    .wave_i(gate_wave_i[2]),
    .row_i(gate_inv_r[11:8]),
    .line_i(line_idx_r),
    .lane_o(gate_nxt[2])
  );
  stpoc_gate_lane u_lane_gate4 (
    .wave_i(gate_wave_i[3]),
    .row_i(gate_inv_r[15:12]),
    .line_i(line_idx_r),
    .lane_o(gate_nxt[3])
  );
  stpoc_gate_lane u_lane_gate5 (
    .wave_i(gate_wave_i[4]),
    .row_i(gate_inv_r[19:16]),
    .line_i(line_idx_r),
    .lane_o(gate_nxt[4])
  );

  // phase pins: first of a pair takes bits 6:4, second bits 2:0
  stpoc_phase_lane u_lane_pha1 (
    .wave_i(phase_wave_i[0]),
    .en_i(pha_r[`STPOC_EN_HI]),
    .src_i(pha_r[`STPOC_SRC_HI]),
    .pol_i(pha_r[`STPOC_POL_HI]),
    .val_o(phase_nxt[0]),
    .oe_o(phase_oe_nxt[0])
  );
  stpoc_phase_lane u_lane_pha2 (
    .wave_i(phase_wave_i[1]),
    .en_i(pha_r[`STPOC_EN_LO]),
    .src_i(pha_r[`STPOC_SRC_LO]),
    .pol_i(pha_r[`STPOC_POL_LO]),
    .val_o(phase_nxt[1]),
    .oe_o(phase_oe_nxt[1])
  );
  stpoc_phase_lane u_lane_phb1 (
    .wave_i(phase_wave_i[2]),
    .en_i(phb_r[`STPOC_EN_HI]),
    .src_i(phb_r[`STPOC_SRC_HI]),
    .pol_i(phb_r[`STPOC_POL_HI]),
    .val_o(phase_nxt[2]),
    .oe_o(phase_oe_nxt[2])
  );
  stpoc_phase_lane u_lane_phb2 (
    .wave_i(phase_wave_i[3]),
    .en_i(phb_r[`STPOC_EN_LO]),
    .src_i(phb_r[`STPOC_SRC_LO]),
    .pol_i(phb_r[`STPOC_POL_LO]),
    .val_o(phase_nxt[3]),
    .oe_o(phase_oe_nxt[3])
  );
  stpoc_phase_lane u_lane_phc1 (
    .wave_i(phase_wave_i[4]),
    .en_i(phc_r[`STPOC_EN_HI]),
    .src_i(phc_r[`STPOC_SRC_HI]),
    .pol_i(phc_r[`STPOC_POL_HI]),
    .val_o(phase_nxt[4]),
    .oe_o(phase_oe_nxt[4])
  );
  stpoc_phase_lane u_lane_phc2 (
    .wave_i(phase_wave_i[5]),
    .en_i(phc_r[`STPOC_EN_LO]),
    .src_i(phc_r[`STPOC_SRC_LO]),
    .pol_i(phc_r[`STPOC_POL_LO]),
    .val_o(phase_nxt[5]),
    .oe_o(phase_oe_nxt[5])
  );

  // output flops; one cycle of latency traded for glitch-free pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_r <= 5'h00;
      phase_r <= 6'h00;
      phase_oe_r <= 6'h00;
    end else begin
      gate_r <= gate_nxt;
      phase_r <= phase_nxt;
      // level keeps following the waveform even while floating, so re-enabling is clean
      phase_oe_r <= phase_oe_nxt;
    end
  end

  // port drive
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign gate_o = gate_r;
  assign phase_o = phase_r;
  assign phase_oe_o = phase_oe_r;
  assign line_index_o = line_idx_r;

endmodule // stpoc_top

// one gate lane: the override bit of the current line flips the wave
module stpoc_gate_lane #(
  parameter integer IDX_W = 2
) (
  input wire wave_i,
  input wire [(1<<IDX_W)-1:0] row_i,
  input wire [IDX_W-1:0] line_i,
  output wire lane_o
);
  // a clear bit passes the waveform, a set bit inverts it
  assign lane_o = wave_i ^ row_i[line_i];
endmodule // stpoc_gate_lane

// one phase pin: source pick, then inversion, then the drive enable
module stpoc_phase_lane #(
  parameter [0:0] FORCED = 1'b1
) (
  input wire wave_i,
  input wire en_i,
  input wire src_i,
  input wire pol_i,
  output wire val_o,
  output wire oe_o
);
  wire picked;

  // forced level overrides the timing waveform before inversion
  assign picked = src_i ? FORCED : wave_i;
  assign val_o = picked ^ pol_i;
  // enable gates the drive only, so the value keeps running underneath
  assign oe_o = en_i;
endmodule // stpoc_phase_lane

// ===== dv/stpoc_sensor.sv
// Purpose: sensor side of the phase clock pins
// Assumes: sensor pads carry weak pull-downs
// Notes: a floated pin reads low, never its last driven value
`timescale 1ns/1ps
module stpoc_sensor (
  input wire [5:0] phase_i,
  input wire [5:0] phase_oe_i,
  output wire [5:0] pin_o
);
  // pull-down wins only where the block lets go of the pin
  assign pin_o = phase_i & phase_oe_i;
endmodule // stpoc_sensor

// ===== dv/stpoc_top_asserts.sv
// Purpose: port checks of stpoc_top
// Assumes: one clock, sync reset active high
// Notes: phase controls are shadowed from bus writes
`timescale 1ns/1ps
module stpoc_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [6:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [5:0] phase_wave_i,
  input wire line_start_i,
  input wire [5:0] phase_o,
  input wire [5:0] phase_oe_o,
  input wire [1:0] line_index_o
);
  logic [3:0] pg_r;
  logic [23:0] pc_r;
  wire [4:0] ix = wb_adr_i[6:2];
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  // shadow copy; only taken writes count, a held request is not retaken
  always @(posedge clk_i) begin
    if (rst_i) begin
      pg_r <= 4'h0;
      pc_r <= {3{8'h44}};
    end else if (wr && ix == 5'h1f) begin
      pg_r <= wb_dat_i[3:0];
    end else if (wr && pg_r == 4'h8 && ix < 5'h03) begin
      pc_r[ix * 8 +: 8] <= wb_dat_i[7:0] & 8'h77;
    end
  end
  // per-pin fields, bit order of phase_o
  wire [5:0] en = {pc_r[18], pc_r[22], pc_r[10], pc_r[14], pc_r[2], pc_r[6]};
  wire [5:0] src = {pc_r[17], pc_r[21], pc_r[9], pc_r[13], pc_r[1], pc_r[5]};
  wire [5:0] pol = {pc_r[16], pc_r[20], pc_r[8], pc_r[12], pc_r[0], pc_r[4]};
  wire [5:0] val = (src | phase_wave_i) ^ pol;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_idle: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  chk_read_upper: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  chk_line_step: assert property (
    line_start_i |=> line_index_o == $past(line_index_o) + 2'd1)
    else $error("line index not advanced");
  chk_line_hold: assert property (
    !line_start_i |=> $stable(line_index_o)) else $error("line index moved");
  chk_phase_enable: assert property (
    !$past(rst_i) |-> phase_oe_o == $past(en)) else $error("bad enable");
  chk_phase_value: assert property (
    !$past(rst_i) |-> phase_o == $past(val)) else $error("bad phase value");
  cover property (line_start_i && line_index_o == 2'd3);
  cover property (wr && ix == 5'h1f);
  cover property (phase_oe_o != 6'h3f);
endmodule // stpoc_chk

bind stpoc_top stpoc_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .phase_wave_i, .line_start_i, .phase_o, .phase_oe_o, .line_index_o);

// ===== dv/tb.sv
// Purpose: random and corner tests of stpoc_top
// Assumes: 20 MHz clock, reset held 12 cycles
// Notes: waves are held still while outputs are compared
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic line_start_i = 0, wb_ack_o;
  logic [6:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [4:0] gate_wave_i = 0, gate_o;
  logic [5:0] phase_wave_i = 0, phase_o, phase_oe_o, pin;
  logic [1:0] line_index_o;
  logic [23:0] c;
  logic [19:0] o;
  integer seed = 32'hc4c725db;
  int error_cnt = 0, n_compared = 0;
  stpoc_top u_stpoc_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gate_wave_i,
    .phase_wave_i, .line_start_i, .gate_o, .phase_o, .phase_oe_o,
    .line_index_o);
  stpoc_sensor u_stpoc_sensor (.phase_i(phase_o), .phase_oe_i(phase_oe_o),
    .pin_o(pin));
  // free-running 50 ns clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: reg %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: pins %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; holds everything until ack is seen at an edge
  task automatic bus(input logic w, input logic [4:0] ix,
      input logic [7:0] d, input logic [3:0] s);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {ix, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    // no limit of its own: a missing ack is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  // low six: pin level with pull-down, high six: enables
  function automatic logic [11:0] exp_ph(input logic [23:0] c,
      input logic [5:0] w);
    logic [2:0] f;
    for (int k = 0; k < 6; k++) begin
      f = c[(k / 2) * 8 + (k % 2 ? 0 : 4) +: 3];
      exp_ph[k] = f[2] & ((f[1] | w[k]) ^ f[0]);
      exp_ph[k + 6] = f[2];
    end
  endfunction
  function automatic logic [4:0] exp_gt(input logic [19:0] o,
      input logic [4:0] w, input logic [1:0] l);
    for (int g = 0; g < 5; g++) exp_gt[g] = w[g] ^ o[g * 4 + l];
  endfunction
  task automatic do_reset;
    rst_i <= 1;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic t_defaults;
    bus(0, 5'h1f, 0, 1);
    cmp_reg(q, 0);
    bus(1, 5'h1f, 8'h08, 1);
    for (int i = 0; i < 3; i++) begin
      bus(0, i[4:0], 0, 1);
      cmp_reg(q, 32'h44);
    end
    cmp_pin({phase_oe_o, 6'h0}, 12'hfc0);
    bus(0, 5'h05, 0, 1);
    cmp_reg(q, 0);
    $display("test defaults done");
  endtask
  task automatic t_gate;
    bus(1, 5'h1f, 8'h07, 1);
    o = 20'($random(seed));
    for (int g = 0; g < 5; g++) bus(1, 5'h19 + g[4:0], {4'ha, o[g*4 +: 4]}, 1);
    bus(0, 5'h1d, 0, 1);
    cmp_reg(q, {28'h0, o[19:16]});
    bus(0, 5'h1e, 0, 1);
    cmp_reg(q, 0);
    gate_wave_i <= 5'($random(seed));
    for (int l = 0; l < 5; l++) begin
      repeat (2) @(posedge clk_i);
      cmp_pin({10'h0, line_index_o}, 12'(l % 4));
      cmp_pin({7'h0, gate_o}, {7'h0, exp_gt(o, gate_wave_i, l[1:0])});
      line_start_i <= 1;
      @(posedge clk_i);
      line_start_i <= 0;
    end
    $display("test gate done");
  endtask
  task automatic t_phase;
    bus(1, 5'h1f, 8'h08, 1);
    // five line pulses in the gate test leave the index at one
    bus(0, 5'h1e, 0, 1);
    cmp_reg(q, 32'h1);
    for (int i = 0; i < 12; i++) begin
      c = i == 0 ? 24'h0 : i == 1 ? 24'h777777 : 24'($random(seed));
      for (int r = 0; r < 3; r++) bus(1, r[4:0], c[r*8 +: 8], 1);
      bus(1, 5'h00, 8'h00, 4'h0);
      phase_wave_i <= 6'($random(seed));
      repeat (2) @(posedge clk_i);
      cmp_pin({phase_oe_o, pin}, exp_ph(c, phase_wave_i));
      for (int r = 0; r < 3; r++) begin
        bus(0, r[4:0], 0, 1);
        cmp_reg(q, {24'h0, c[r*8 +: 8] & 8'h77});
      end
    end
    $display("test phase done");
  endtask
  task automatic print_verdict;
    $display("compared %0d wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence, with a second reset in mid-run
  initial begin
    do_reset;
    t_defaults;
    t_gate;
    t_phase;
    do_reset;
    t_defaults;
    print_verdict;
  end
  // watchdog, well above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    print_verdict;
  end
endmodule // tb
